// ===== rtl/lsw_pkg.sv
// constants shared by the low-side switch mode and channel control
// ----------------------------------------------------------------------------
// Operation
// R01 - supply power-on reset: defaults, idle, channels off
// R02 - reset pad low: defaults, quiescent standby
// R03 - reset pad active low, pulled down
// R04 - limp-home pad high: limp mode, registers reset
// R05 - limp mode: pads one-four drive channels one-four
// R06 - limp mode: channels five-eight forced off
// R07 - limp mode: serial traffic ignored
// R08 - limp-home wins over reset pad
// R09 - limp-home from standby wakes into limp
// R10 - limp exit: reset, then standby or idle
// R11 - first frame after limp flags prior invalid
// R12 - select field picks driving pad per channel
// R13 - pad high equals on, low equals off
// R14 - serial control follows per-channel switch bit
// R15 - open control pad reads low
// ----------------------------------------------------------------------------
package lsw_pkg;

  // channel and pad counts, select field width
  localparam int CHANNELS   = 8;
  localparam int PADS       = 4;
  localparam int LIMP_CHANS = 4;
  localparam int SEL_W      = 3;

  // select field codes: zero is serial control, one to four name a pad
  localparam logic [2:0] SEL_SERIAL = 3'h0;
  localparam logic [2:0] SEL_PAD1   = 3'h1;

  // values after reset
  localparam logic [7:0] SWITCH_RESET = 8'h00;
  localparam logic [2:0] SELECT_RESET = 3'h0;
  localparam logic [7:0] OUTPUT_RESET = 8'h00;

  // pin synchroniser: pads pulled down read low before first sample
  localparam int         SYNC_PINS    = 8;
  localparam logic [7:0] PIN_RESET    = 8'h00;

  // operating states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STANDBY,
    ST_LIMP
  } lsw_state_type;

endpackage

// ===== rtl/lsw_mode_control.sv
// mode, limp-home and channel control of an eight-channel low-side switch
`timescale 1ns/10ps
`default_nettype none

module lsw_mode_control #(
  parameter int CHANNELS = lsw_pkg::CHANNELS  // output channel count
)(
  input  wire logic                    clk,                // 100 MHz clock
  input  wire logic                    reset,              // sync reset, high
  input  wire logic                    porDigital,         // digital supply por pin
  input  wire logic                    porAnalog,          // analog supply por pin
  input  wire logic                    resetPadN,          // reset pad, low active
  input  wire logic                    limp_home_pad,      // limp-home pad
  input  wire logic [3:0]              controlPads,        // pads one (bit 0) to four
  input  wire logic                    writeStrobe,        // serial write, one cycle
  input  wire logic [7:0]              writeSwitch,        // per-channel switch bits
  input  wire logic [7:0][2:0]         writeSelect,        // per-channel pad_select_field
  input  wire logic                    frameDone,          // serial frame ended, pulse
  output logic      [7:0]              outputChannels,     // channel on levels
  output logic                         modeStandby,        // standby state
  output logic                         modeLimp,           // limp-home state
  output logic                         prior_frame_invalid_flag // flag for next reply
);

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  if (CHANNELS != 8)
  begin : g_bad_channels
    $error("lsw_mode_control serves exactly eight channels");
  end

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  logic [7:0] pinRaw;
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [7:0] sync3_q;
  logic [7:0] pinF_q;
  logic [7:0] pinF_d;

  assign pinRaw = {porDigital, porAnalog, resetPadN, limp_home_pad, controlPads};

  // a change counts only when the second and third stage agree
  genvar gi;
  for (gi = 0; gi < lsw_pkg::SYNC_PINS; gi++)
  begin : g_pin
    always_comb
    begin
      pinF_d[gi] = (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi] : pinF_q[gi];
    end
  end

  // pulled-down pads read low until sampled; floating reset pad holds reset
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sync1_q <= lsw_pkg::PIN_RESET;
      sync2_q <= lsw_pkg::PIN_RESET;
      sync3_q <= lsw_pkg::PIN_RESET;
      pinF_q  <= lsw_pkg::PIN_RESET;  // R15 R03
    end
    else
    begin
      sync1_q <= pinRaw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pinF_q  <= pinF_d;
    end
  end

  logic [3:0] padF;
  logic       limpF;
  logic       rstPadNF;
  logic       porF;

  assign padF     = pinF_q[3:0];
  assign limpF    = pinF_q[4];
  assign rstPadNF = pinF_q[5];
  assign porF     = pinF_q[6] | pinF_q[7];

  // --------------------------------------------------------------------------
  // mode and serial registers
  // --------------------------------------------------------------------------
  lsw_pkg::lsw_state_type state_q;
  lsw_pkg::lsw_state_type state_d;
  logic [7:0]             switch_q;
  logic [7:0]             switch_d;
  logic [7:0][2:0]        select_q;
  logic [7:0][2:0]        select_d;
  logic                   flag_q;
  logic                   flag_d;

  // por first, then limp-home over the reset pad, then limp exit
  always_comb
  begin
    state_d  = state_q;
    switch_d = switch_q;
    select_d = select_q;
    flag_d   = flag_q;
    if (frameDone && state_q != lsw_pkg::ST_LIMP)
      flag_d = 1'b0;  // R11
    if (porF)
    begin
      state_d  = lsw_pkg::ST_IDLE;  // R01
      switch_d = lsw_pkg::SWITCH_RESET;
      select_d = '0;
    end
    else if (limpF)
    begin
      state_d  = lsw_pkg::ST_LIMP;  // R04 R08 R09
      switch_d = lsw_pkg::SWITCH_RESET;
      select_d = '0;  // R07
    end
    else if (state_q == lsw_pkg::ST_LIMP)
    begin
      // set wins over a clear from a frame ending in the same cycle
      flag_d   = 1'b1;  // R11
      switch_d = lsw_pkg::SWITCH_RESET;  // R10
      select_d = '0;
      state_d  = rstPadNF ? lsw_pkg::ST_IDLE : lsw_pkg::ST_STANDBY;  // R10
    end
    else if (!rstPadNF)
    begin
      state_d  = lsw_pkg::ST_STANDBY;  // R02 R03
      switch_d = lsw_pkg::SWITCH_RESET;
      select_d = '0;
    end
    else
    begin
      state_d = lsw_pkg::ST_IDLE;
      if (writeStrobe)
      begin
        switch_d = writeSwitch;  // R14
        select_d = writeSelect;  // R12
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q  <= lsw_pkg::ST_IDLE;
      switch_q <= lsw_pkg::SWITCH_RESET;
      select_q <= '0;
      flag_q   <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      switch_q <= switch_d;
      select_q <= select_d;
      flag_q   <= flag_d;
    end
  end

  // --------------------------------------------------------------------------
  // channel drive
  // --------------------------------------------------------------------------
  logic [7:0] out_q;
  logic [7:0] out_d;
  logic       standby_q;
  logic       standby_d;
  logic       limp_q;
  logic       limp_d;

  // one pass per channel; select codes above four leave the channel off
  for (gi = 0; gi < lsw_pkg::CHANNELS; gi++)
  begin : g_chan
    always_comb
    begin
      out_d[gi] = 1'b0;
      unique case (state_q)
        lsw_pkg::ST_LIMP:
          if (gi < lsw_pkg::LIMP_CHANS)
            out_d[gi] = padF[gi % lsw_pkg::PADS];  // R05 R06
        lsw_pkg::ST_STANDBY:
          out_d[gi] = 1'b0;  // R02
        lsw_pkg::ST_IDLE:
          if (select_q[gi] == lsw_pkg::SEL_SERIAL)
            out_d[gi] = switch_q[gi];  // R14
          else if (select_q[gi] <= 3'h4)
            out_d[gi] = padF[2'(select_q[gi] - lsw_pkg::SEL_PAD1)];  // R12 R13
        default:
          out_d[gi] = 1'b0;
      endcase
    end
  end

  always_comb
  begin
    standby_d = (state_q == lsw_pkg::ST_STANDBY);
    limp_d    = (state_q == lsw_pkg::ST_LIMP);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      out_q     <= lsw_pkg::OUTPUT_RESET;
      standby_q <= 1'b0;
      limp_q    <= 1'b0;
    end
    else
    begin
      out_q     <= out_d;
      standby_q <= standby_d;
      limp_q    <= limp_d;
    end
  end

  assign outputChannels           = out_q;
  assign modeStandby              = standby_q;
  assign modeLimp                 = limp_q;
  assign prior_frame_invalid_flag = flag_q;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  limp_high_off_a: assert property (state_q == lsw_pkg::ST_LIMP |=> out_q[7:4] == 4'h0) // R06
    else $error("limp mode drove an upper channel");
  limp_pad_route_a: assert property (state_q == lsw_pkg::ST_LIMP
    |=> out_q[3:0] == $past(padF)) // R05
    else $error("limp mode channel does not follow its pad");
  standby_off_a: assert property (state_q == lsw_pkg::ST_STANDBY |=> out_q == 8'h00) // R02
    else $error("channel on in standby");
  limp_priority_a: assert property (limpF && !porF |=> state_q == lsw_pkg::ST_LIMP) // R08
    else $error("limp-home pad did not win");
  limp_regs_a: assert property (state_q == lsw_pkg::ST_LIMP
    |-> switch_q == 8'h00 && select_q == '0) // R07
    else $error("serial state changed in limp mode");
  limp_exit_a: assert property (state_q == lsw_pkg::ST_LIMP && !porF && !limpF
    |=> flag_q && !limp_d) // R11
    else $error("prior frame flag missing after limp");
  por_idle_a: assert property (porF |=> state_q == lsw_pkg::ST_IDLE ##1 out_q == 8'h00) // R01
    else $error("power-on reset did not reach idle");
  serial_drive_a: assert property (state_q == lsw_pkg::ST_IDLE && select_q[0] == 3'h0
    |=> out_q[0] == $past(switch_q[0])) // R14
    else $error("serial channel ignores its switch bit");
  pad_drive_a: assert property (state_q == lsw_pkg::ST_IDLE && select_q[2] == 3'h3
    |=> out_q[2] == $past(padF[2])) // R13
    else $error("pad channel ignores its pad");

endmodule // lsw_mode_control

`default_nettype wire

// ===== verification/lsw_host_model.sv
// host model: pad driver and abstracted serial master
`timescale 1ns/10ps
`default_nettype none

module lsw_host_model (
  input  wire logic       clk,           // bench clock
  output logic            porDigital,    // digital por pin
  output logic            porAnalog,     // analog por pin
  output logic            resetPadN,     // reset pad, low active
  output logic            limp_home_pad, // limp-home pad
  output logic [3:0]      controlPads,   // control pads one to four
  output logic            writeStrobe,   // write pulse
  output logic [7:0]      writeSwitch,   // switch bits
  output logic [7:0][2:0] writeSelect,   // select fields
  output logic            frameDone      // frame end pulse
);
  // pads start at their pulled-down level, so the device starts in reset
  initial
  begin
    {porDigital, porAnalog, resetPadN, limp_home_pad, controlPads} = '0;
    {writeStrobe, writeSwitch, writeSelect, frameDone} = '0;
  end

  // pin levels move just after an edge
  task automatic pins(input logic lh, input logic rn, input logic [3:0] pd);
    @(posedge clk);
    #1 limp_home_pad = lh;
    resetPadN = rn;
    controlPads = pd;
  endtask

  task automatic por(input logic d, input logic a);
    @(posedge clk);
    #1 porDigital = d;
    porAnalog = a;
  endtask

  // released data lines show the inverse so stale values cannot pass
  task automatic write(input logic [7:0] sw, input logic [23:0] sel);
    @(posedge clk);
    #1 writeStrobe = 1'b1;
    writeSwitch = sw;
    writeSelect = sel;
    @(posedge clk);
    #1 writeStrobe = 1'b0;
    writeSwitch = ~sw;
    writeSelect = ~sel;
  endtask

  task automatic frame;
    @(posedge clk);
    #1 frameDone = 1'b1;
    @(posedge clk);
    #1 frameDone = 1'b0;
  endtask
endmodule // lsw_host_model

`default_nettype wire

// ===== verification/tb.sv
// self-checking bench of the low-side switch mode control
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic clk, reset, porDigital, porAnalog, resetPadN, limp_home_pad;
  logic writeStrobe, frameDone, modeStandby, modeLimp, prior_frame_invalid_flag;
  logic [3:0] controlPads;
  logic [7:0] writeSwitch, outputChannels;
  logic [7:0][2:0] writeSelect;
  int fails = 0;
  int totalChecks = 0;
  int cycles = 0;

  lsw_host_model lsw_host_model_inst (.clk, .porDigital, .porAnalog, .resetPadN,
    .limp_home_pad, .controlPads, .writeStrobe, .writeSwitch, .writeSelect, .frameDone);
  lsw_mode_control lsw_mode_control_inst (.clk, .reset, .porDigital, .porAnalog,
    .resetPadN, .limp_home_pad, .controlPads, .writeStrobe, .writeSwitch, .writeSelect,
    .frameDone, .outputChannels, .modeStandby, .modeLimp, .prior_frame_invalid_flag);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // sample two ns after the edge so its updates have landed
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic modes(input logic [7:0] exp);
    check({5'h00, prior_frame_invalid_flag, modeStandby, modeLimp}, exp);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    settle(4);
    modes(8'h02);
    check(outputChannels, lsw_pkg::OUTPUT_RESET);
    lsw_host_model_inst.pins(1'b0, 1'b1, 4'h0);
    settle(8);
    modes(8'h00);
  endtask

  task automatic t_serial;
    lsw_host_model_inst.write(8'hA5, 24'h0);
    settle(1);
    check(outputChannels, 8'hA5);
    lsw_host_model_inst.write(8'h5A, 24'h0);
    settle(1);
    check(outputChannels, 8'h5A);
  endtask

  // channels 4..6 use codes 5..7 and must stay off despite their bits
  task automatic t_pads;
    lsw_host_model_inst.write(8'hFF, {3'h0, 3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1});
    lsw_host_model_inst.pins(1'b0, 1'b1, 4'h5);
    settle(8);
    check(outputChannels, 8'h85);
    lsw_host_model_inst.pins(1'b0, 1'b1, 4'hA);
    settle(8);
    check(outputChannels, 8'h8A);
    lsw_host_model_inst.pins(1'b0, 1'b1, 4'h0);
    settle(8);
    check(outputChannels, 8'h80);
  endtask

  task automatic t_limp;
    lsw_host_model_inst.pins(1'b1, 1'b0, 4'h6);
    settle(8);
    modes(8'h01);
    check(outputChannels, 8'h06);
    lsw_host_model_inst.write(8'hFF, 24'h0);
    settle(3);
    check(outputChannels, 8'h06);
    lsw_host_model_inst.pins(1'b0, 1'b0, 4'h6);
    settle(8);
    modes(8'h06);
    lsw_host_model_inst.pins(1'b0, 1'b1, 4'h6);
    settle(8);
    check(outputChannels, 8'h00);
    lsw_host_model_inst.frame();
    settle(1);
    modes(8'h00);
  endtask

  task automatic t_wake;
    lsw_host_model_inst.pins(1'b0, 1'b0, 4'h1);
    settle(8);
    modes(8'h02);
    lsw_host_model_inst.pins(1'b1, 1'b0, 4'h1);
    settle(8);
    modes(8'h01);
    check(outputChannels, 8'h01);
    lsw_host_model_inst.pins(1'b0, 1'b1, 4'h0);
    lsw_host_model_inst.frame();
    settle(8);
    // a frame ending inside limp leaves the flag for the next frame
    modes(8'h04);
    check(outputChannels, 8'h00);
    lsw_host_model_inst.frame();
    settle(1);
    modes(8'h00);
  endtask

  // each supply's power-on reset clears the switch bits and leaves idle
  task automatic t_por;
    for (int i = 0; i < 2; i++)
    begin
      lsw_host_model_inst.write(8'hFF, 24'h0);
      settle(1);
      check(outputChannels, 8'hFF);
      lsw_host_model_inst.por(i == 0, i == 1);
      settle(8);
      check(outputChannels, lsw_pkg::OUTPUT_RESET);
      lsw_host_model_inst.por(1'b0, 1'b0);
      settle(8);
      modes(8'h00);
      check(outputChannels, lsw_pkg::OUTPUT_RESET);
    end
  endtask

  // ----------------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // the whole run needs under two hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fails++;
      final_report();
    end
  end

  initial
  begin
    reset = 1'b1;
    repeat (12) @(posedge clk);
    #1 reset = 1'b0;
    t_reset();
    t_serial();
    t_pads();
    t_limp();
    t_wake();
    t_por();
    final_report();
  end
endmodule // tb

`default_nettype wire
